/* pmx_config.sv */
// Per-port PHY mode and crossover configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "pmx_defines.svh"
module pmx_config
   import pmx_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        manual_mdix_strap,
   input  wire logic        auto_mdix_strap,
   output logic             crossover_active,
   output logic             crossover_auto,
   output logic             heartbeat_test_disable,
   output logic             rx_pll_ref_lock,
   output logic             power_down,
   output logic             repeater_mode,
   output logic             crs_on_transmit,
   output logic [15:0]      basic_control,
   output logic [15:0]      autoneg_advert
);
   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [15:0] phy_special_control_reg;
   logic [2:0]  mode_reg;
   logic [15:0] basic_reg;
   logic [15:0] advert_reg;
   logic        soft_reset_reg;
   pmx_bus_t    bus_reg;
   logic [2:0]  strap_man_sync_reg;
   logic [2:0]  strap_auto_sync_reg;
   logic        strap_man_reg;
   logic        strap_auto_reg;
   logic        force_en;
   logic        advert_en;
   logic [15:0] basic_val;
   logic [15:0] advert_val;
   logic        crs_tx_too;
   logic        repeater;
   logic        pdn;
   logic        wr_go;
   logic        rd_go;
   logic [15:0] wdata;
   logic [15:0] basic_fmask;
   logic [15:0] basic_eff;
   logic [15:0] advert_eff;
   logic [15:0] rd_mux;
   pmx_xover_t  xover;

   pmx_mode_decode u_decode (
      .mode       (mode_reg),
      .force_en   (force_en),
      .advert_en  (advert_en),
      .basic_val  (basic_val),
      .advert_val (advert_val),
      .crs_tx_too (crs_tx_too),
      .repeater   (repeater),
      .power_down (pdn)
   );

   // ****************************************************************
   // Avalon-MM slave: one wait cycle, then ack
   // ****************************************************************
   assign wdata = avs_writedata[15:0];
   assign wr_go = avs_write && (bus_reg == PMX_BS_ACK);
   assign rd_go = avs_read && (bus_reg == PMX_BS_ACK);
   assign avs_waitrequest = (avs_read || avs_write) && (bus_reg != PMX_BS_ACK);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_reg <= PMX_BS_IDLE;
      end else begin
         unique case (bus_reg)
            PMX_BS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_reg <= PMX_BS_ACK;
               end
            end
            PMX_BS_ACK: begin
               bus_reg <= PMX_BS_IDLE;
            end
            default: begin
               bus_reg <= PMX_BS_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Strap synchronisers
   // ****************************************************************
   // Change accepted only when stages two and three agree
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strap_man_sync_reg  <= 3'h0;
         strap_auto_sync_reg <= 3'h0;
         strap_man_reg       <= 1'b0;
         strap_auto_reg      <= 1'b0;
      end else begin
         strap_man_sync_reg  <= {strap_man_sync_reg[1:0], manual_mdix_strap};
         strap_auto_sync_reg <= {strap_auto_sync_reg[1:0], auto_mdix_strap};
         if (strap_man_sync_reg[1] == strap_man_sync_reg[2]) begin
            strap_man_reg <= strap_man_sync_reg[2];
         end
         if (strap_auto_sync_reg[1] == strap_auto_sync_reg[2]) begin
            strap_auto_reg <= strap_auto_sync_reg[2];
         end
      end
   end

   // ****************************************************************
   // Special control register
   // ****************************************************************
   // Soft reset takes the cleared bits back; source select survives it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phy_special_control_reg <= `PMX_SPECIAL_RST;
      end else if (soft_reset_reg) begin
         phy_special_control_reg[`PMX_BIT_AUTO_EN] <= 1'b0;
         phy_special_control_reg[`PMX_BIT_MAN_ST]  <= 1'b0;
         phy_special_control_reg[`PMX_BIT_SQE_OFF] <= 1'b0;
         phy_special_control_reg[`PMX_BIT_PLL_REF] <= 1'b0;
      end else if (wr_go && avs_address == `PMX_IDX_SPECIAL) begin
         // Bit 12 and status bits are masked off
         phy_special_control_reg <= wdata & `PMX_SPECIAL_WMASK;
      end
   end

   // ****************************************************************
   // Mode field and soft reset
   // ****************************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_reg <= `PMX_MODE_RST;
      end else if (wr_go && avs_address == `PMX_IDX_MODE) begin
         mode_reg <= wdata[`PMX_MODE_LSB +: 3];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= wr_go && avs_address == `PMX_IDX_RESET &&
                           wdata[`PMX_BIT_SOFT_RST];
      end
   end

   // ****************************************************************
   // Basic control and advertisement
   // ****************************************************************
   // Mode 111 leaves bits 13 and 8 to software
   assign basic_fmask = (mode_reg == PMX_MALL) ? 16'h1400 :
                        `PMX_BASIC_FMASK;
   assign basic_eff  = force_en ?
      ((basic_reg & ~basic_fmask) | (basic_val & basic_fmask)) :
      basic_reg;
   assign advert_eff = advert_en ?
      ((advert_reg & ~`PMX_ADVERT_FMASK) |
       (advert_val & `PMX_ADVERT_FMASK)) :
      advert_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         basic_reg <= `PMX_BASIC_RST;
      end else if (wr_go && avs_address == `PMX_IDX_BASIC) begin
         basic_reg <= wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         advert_reg <= `PMX_ADVERT_RST;
      end else if (wr_go && avs_address == `PMX_IDX_ADVERT) begin
         advert_reg <= wdata;
      end
   end

   // ****************************************************************
   // Crossover selection
   // ****************************************************************
   always_comb begin
      xover = PMX_XO_NONE;
      if (phy_special_control_reg[`PMX_BIT_SRC_SEL]) begin
         // Pair 11 is not to be written; treated as auto
         if (phy_special_control_reg[`PMX_BIT_AUTO_EN]) begin
            xover = PMX_XO_AUTO;
         end else if (phy_special_control_reg[`PMX_BIT_MAN_ST]) begin
            xover = PMX_XO_CROSS;
         end
      end else if (strap_auto_reg) begin
         xover = PMX_XO_AUTO;
      end else if (strap_man_reg) begin
         xover = PMX_XO_CROSS;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crossover_active       <= 1'b0;
         crossover_auto         <= 1'b0;
         heartbeat_test_disable <= 1'b0;
         rx_pll_ref_lock        <= 1'b0;
         power_down             <= 1'b0;
         repeater_mode          <= 1'b0;
         crs_on_transmit        <= 1'b0;
         basic_control          <= `PMX_BASIC_RST;
         autoneg_advert         <= `PMX_ADVERT_RST;
      end else begin
         crossover_active       <= (xover == PMX_XO_CROSS);
         crossover_auto         <= (xover == PMX_XO_AUTO);
         heartbeat_test_disable <=
            phy_special_control_reg[`PMX_BIT_SQE_OFF];
         rx_pll_ref_lock        <=
            phy_special_control_reg[`PMX_BIT_PLL_REF];
         power_down             <= pdn;
         repeater_mode          <= repeater;
         crs_on_transmit        <= crs_tx_too;
         basic_control          <= basic_eff;
         autoneg_advert         <= advert_eff;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_comb begin
      rd_mux = 16'h0000;
      unique case (avs_address)
         `PMX_IDX_SPECIAL: rd_mux = phy_special_control_reg;
         `PMX_IDX_MODE:    rd_mux = {8'h00, mode_reg, 5'h00};
         `PMX_IDX_BASIC:   rd_mux = basic_eff;
         `PMX_IDX_ADVERT:  rd_mux = advert_eff;
         default:          rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && bus_reg == PMX_BS_IDLE) begin
         avs_readdata <= {16'h0000, rd_mux};
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_mode3_basic: assert property (@(posedge clock) disable iff (rst)
      mode_reg == PMX_M100F |=> basic_control[13] && basic_control[8] &&
      !basic_control[12] && !basic_control[10])
      else $error("mode 011 basic bits wrong");
   a_mode4_adv: assert property (@(posedge clock) disable iff (rst)
      mode_reg == PMX_MAN100 |=> autoneg_advert[8:5] == 4'h4 &&
      basic_control[13:12] == 2'h3 && crs_on_transmit)
      else $error("mode 100 settings wrong");
   a_mode5_rep: assert property (@(posedge clock) disable iff (rst)
      mode_reg == PMX_MREP |=> repeater_mode && !crs_on_transmit &&
      autoneg_advert[8:5] == 4'h4)
      else $error("mode 101 settings wrong");
   a_mode6_pdn: assert property (@(posedge clock) disable iff (rst)
      mode_reg == PMX_MPDN |=> power_down &&
      basic_control == $past(basic_reg))
      else $error("mode 110 touched control bits");
   a_mode7_all: assert property (@(posedge clock) disable iff (rst)
      mode_reg == PMX_MALL |=> autoneg_advert[8:5] == 4'hF &&
      basic_control[12] && !basic_control[10])
      else $error("mode 111 settings wrong");
   a_strap_path: assert property (@(posedge clock) disable iff (rst)
      !phy_special_control_reg[`PMX_BIT_SRC_SEL] &&
      strap_auto_reg |=> crossover_auto)
      else $error("strap crossover not followed");
   a_reg_manual: assert property (@(posedge clock) disable iff (rst)
      phy_special_control_reg[15:13] == 3'h5 |=>
      crossover_active && !crossover_auto)
      else $error("manual crossover decode wrong");
   a_soft_clear: assert property (@(posedge clock) disable iff (rst)
      soft_reset_reg |=> phy_special_control_reg[14:13] == 2'h0 &&
      phy_special_control_reg[11:10] == 2'h0)
      else $error("soft reset did not clear bits");
   a_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
      !phy_special_control_reg[`PMX_BIT_RSVD12])
      else $error("reserved bit 12 set");
   a_sqe_follow: assert property (@(posedge clock) disable iff (rst)
      ##1 heartbeat_test_disable ==
      $past(phy_special_control_reg[`PMX_BIT_SQE_OFF]))
      else $error("heartbeat disable mismatch");
   c_write_special: cover property (@(posedge clock)
      wr_go && avs_address == `PMX_IDX_SPECIAL);
   c_soft_reset: cover property (@(posedge clock) soft_reset_reg);
   c_mode_change: cover property (@(posedge clock)
      mode_reg != $past(mode_reg));
   c_read_ack: cover property (@(posedge clock) rd_go);
endmodule // pmx_config
`default_nettype wire

/* pmx_defines.svh */
// Constants for the PHY mode and crossover configuration block
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH
// ****************************************************************
// Register indices (word addresses)
// ****************************************************************
`define PMX_IDX_SPECIAL   5'h1B
`define PMX_IDX_MODE      5'h12
`define PMX_IDX_BASIC     5'h00
`define PMX_IDX_ADVERT    5'h04
`define PMX_IDX_RESET     5'h1F
// ****************************************************************
// Field positions
// ****************************************************************
`define PMX_BIT_SRC_SEL   15
`define PMX_BIT_AUTO_EN   14
`define PMX_BIT_MAN_ST    13
`define PMX_BIT_RSVD12    12
`define PMX_BIT_SQE_OFF   11
`define PMX_BIT_PLL_REF   10
`define PMX_MODE_LSB      5
`define PMX_BIT_PHY_RST   15
`define PMX_BIT_SOFT_RST  0
// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define PMX_SPECIAL_RST   16'h0000
`define PMX_SPECIAL_WMASK 16'hEC00
`define PMX_MODE_RST      3'h7
`define PMX_BASIC_RST     16'h3100
`define PMX_ADVERT_RST    16'h01E1
`define PMX_BASIC_FMASK   16'h3500
`define PMX_ADVERT_FMASK  16'h01E0
`define PMX_BUS_WAIT      1
`endif

/* pmx_pkg.sv */
// Types for the PHY mode and crossover configuration block
package pmx_pkg;
   typedef enum logic [2:0] {
      PMX_M10H   = 3'h0,
      PMX_M10F   = 3'h1,
      PMX_M100H  = 3'h2,
      PMX_M100F  = 3'h3,
      PMX_MAN100 = 3'h4,
      PMX_MREP   = 3'h5,
      PMX_MPDN   = 3'h6,
      PMX_MALL   = 3'h7
   } pmx_mode_t;
   typedef enum logic [2:0] {
      PMX_XO_NONE  = 3'h1,
      PMX_XO_CROSS = 3'h2,
      PMX_XO_AUTO  = 3'h4
   } pmx_xover_t;
   typedef enum logic [1:0] {
      PMX_BS_IDLE = 2'h1,
      PMX_BS_ACK  = 2'h2
   } pmx_bus_t;
endpackage

/* pmx_mode_decode.sv */
// Decoder from operating-mode field to forced control/advert bits
`timescale 1ns/1ns
`default_nettype none
`include "pmx_defines.svh"
module pmx_mode_decode
   import pmx_pkg::*;
(
   input  wire logic [2:0]  mode,
   output logic             force_en,
   output logic             advert_en,
   output logic [15:0]      basic_val,
   output logic [15:0]      advert_val,
   output logic             crs_tx_too,
   output logic             repeater,
   output logic             power_down
);
   always_comb begin
      force_en   = 1'b1;
      advert_en  = 1'b0;
      basic_val  = 16'h0000;
      advert_val = 16'h0000;
      crs_tx_too = 1'b0;
      repeater   = 1'b0;
      power_down = 1'b0;
      unique case (pmx_mode_t'(mode))
         PMX_M10H: begin
            crs_tx_too = 1'b1;
         end
         PMX_M10F: begin
            basic_val = 16'h0100;
         end
         PMX_M100H: begin
            basic_val  = 16'h2000;
            crs_tx_too = 1'b1;
         end
         PMX_M100F: begin
            basic_val = 16'h2100;
         end
         PMX_MAN100: begin
            basic_val  = 16'h3000;
            advert_en  = 1'b1;
            advert_val = 16'h0080;
            crs_tx_too = 1'b1;
         end
         PMX_MREP: begin
            basic_val  = 16'h3000;
            advert_en  = 1'b1;
            advert_val = 16'h0080;
            repeater   = 1'b1;
         end
         PMX_MPDN: begin
            force_en   = 1'b0;
            power_down = 1'b1;
         end
         PMX_MALL: begin
            // Only bits 12 and 10 are forced; 13 and 8 stay free
            force_en   = 1'b1;
            basic_val  = 16'h1000;
            advert_en  = 1'b1;
            advert_val = 16'h01E0;
            crs_tx_too = 1'b1;
         end
      endcase
   end
endmodule // pmx_mode_decode
`default_nettype wire

/* pmx_testbench.sv */
// Self-checking testbench for the PHY mode and crossover register bank
`timescale 1ns/1ns
`default_nettype none
`include "pmx_defines.svh"
module testbench
   import pmx_pkg::*;
;
   logic        clock;
   logic        rst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        manual_mdix_strap;
   logic        auto_mdix_strap;
   logic        crossover_active;
   logic        crossover_auto;
   logic        heartbeat_test_disable;
   logic        rx_pll_ref_lock;
   logic        power_down;
   logic        repeater_mode;
   logic        crs_on_transmit;
   logic [15:0] basic_control;
   logic [15:0] autoneg_advert;
   int          err_count;
   int          cmp_count;
   logic [31:0] rd;

   pmx_config dut_u (
      .clock                  (clock),
      .rst                    (rst),
      .avs_address            (avs_address),
      .avs_read               (avs_read),
      .avs_write              (avs_write),
      .avs_writedata          (avs_writedata),
      .avs_readdata           (avs_readdata),
      .avs_waitrequest        (avs_waitrequest),
      .manual_mdix_strap      (manual_mdix_strap),
      .auto_mdix_strap        (auto_mdix_strap),
      .crossover_active       (crossover_active),
      .crossover_auto         (crossover_auto),
      .heartbeat_test_disable (heartbeat_test_disable),
      .rx_pll_ref_lock        (rx_pll_ref_lock),
      .power_down             (power_down),
      .repeater_mode          (repeater_mode),
      .crs_on_transmit        (crs_on_transmit),
      .basic_control          (basic_control),
      .autoneg_advert         (autoneg_advert)
   );

   // ****************************************************************
   // Clock, closing and watchdog
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Whole run is about 150 cycles; this leaves wide margin
   initial begin
      #200000;
      err_count++;
      $display("Error at %0t: watchdog got %h exp %h", $time, cmp_count, 0);
      stop_test();
   end

   // ****************************************************************
   // Bus and compare helpers
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Entered just after a rising edge; leaves one idle edge behind it
   task automatic bus_xfer(input logic wr, input logic [4:0] a,
                           input logic [31:0] d, output logic [31:0] q);
      int n;
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("Error at %0t: no answer got %h exp %h", $time, n, 0);
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus_xfer(1'b1, a, d, dummy);
      repeat (2) @(posedge clock);
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [31:0] q);
      bus_xfer(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic chk_xo(input logic act, input logic aut, input string w);
      check(32'(crossover_active), 32'(act), w);
      check(32'(crossover_auto), 32'(aut), w);
   endtask

   function automatic logic [3:0] ctl_bits(input logic [15:0] b);
      return {b[13], b[12], b[10], b[8]};
   endfunction

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      manual_mdix_strap = 1'b0;
      auto_mdix_strap = 1'b0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);

      // Reset values of the special register and mode 111 defaults
      rd_reg(`PMX_IDX_SPECIAL, rd);
      check(rd, 32'h0000_0000, "special reset");
      check(32'(heartbeat_test_disable), 32'h0, "sqe rst");
      check(32'(rx_pll_ref_lock), 32'h0, "pll rst");
      check(32'(autoneg_advert[8:5]), 32'hF, "adv rst");
      $display("test reset done");

      // Walk every mode back to back; each write must re-force
      for (int m = 0; m <= 7; m++) begin
         wr_reg(`PMX_IDX_MODE, 32'(m) << `PMX_MODE_LSB);
         rd_reg(`PMX_IDX_MODE, rd);
         check(32'(rd[7:5]), 32'(m), "mode readback");
         check(32'(power_down), 32'(m == 6), "power down");
         check(32'(repeater_mode), 32'(m == 5), "repeater");
         case (m)
            0, 1, 2: begin
               check(32'(ctl_bits(basic_control)),
                     (m == 2) ? 32'h8 : 32'(m), "m012");
               check(32'(crs_on_transmit), 32'(m != 1), "m012 crs");
            end
            6: begin
               check(32'(basic_control), 32'(`PMX_BASIC_RST), "m6 b");
               check(32'(autoneg_advert), 32'(`PMX_ADVERT_RST), "m6 a");
            end
            3: begin
               check(32'(ctl_bits(basic_control)), 32'h9, "m3");
               check(32'(crs_on_transmit), 32'h0, "m3 crs");
            end
            4, 5: begin
               check(32'(ctl_bits(basic_control)), 32'hC, "m45");
               check(32'(autoneg_advert[8:5]), 32'h4, "m45 adv");
               check(32'(crs_on_transmit), 32'(m == 4), "crs");
            end
            7: begin
               check(32'(basic_control[12]), 32'h1, "m7 an");
               check(32'(basic_control[10]), 32'h0, "m7 b10");
               check(32'(autoneg_advert[8:5]), 32'hF, "m7 adv");
            end
            default: ;
         endcase
      end
      $display("test modes done");

      // Bit 12 and bits 9:0 ignore writes; 11 and 10 reach outputs
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_DFFF);
      rd_reg(`PMX_IDX_SPECIAL, rd);
      check(rd, 32'h0000_CC00, "special rw");
      check(32'(heartbeat_test_disable), 32'h1, "sqe set");
      check(32'(rx_pll_ref_lock), 32'h1, "pll set");
      $display("test special done");

      // Register-selected crossover: 00 none, 01 cross, 10 auto
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_8000);
      chk_xo(1'b0, 1'b0, "xo 00");
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_A000);
      chk_xo(1'b1, 1'b0, "xo 01");
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_C000);
      auto_mdix_strap <= 1'b0;
      manual_mdix_strap <= 1'b1;
      repeat (6) @(posedge clock);
      chk_xo(1'b0, 1'b1, "xo 10 over straps");
      // Straps govern once bit 15 clears, despite bit 14 left set
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_4000);
      repeat (6) @(posedge clock);
      chk_xo(1'b1, 1'b0, "strap manual");
      auto_mdix_strap <= 1'b1;
      repeat (6) @(posedge clock);
      chk_xo(1'b0, 1'b1, "strap auto");
      auto_mdix_strap <= 1'b0;
      manual_mdix_strap <= 1'b0;
      repeat (6) @(posedge clock);
      chk_xo(1'b0, 1'b0, "strap none");
      $display("test crossover done");

      // Soft reset clears 14,13,11,10 and keeps the source select
      wr_reg(`PMX_IDX_SPECIAL, 32'h0000_AC00);
      wr_reg(`PMX_IDX_RESET, 32'h0000_0001);
      rd_reg(`PMX_IDX_SPECIAL, rd);
      check(rd, 32'h0000_8000, "soft reset");
      check(32'(heartbeat_test_disable), 32'h0, "sqe clr");
      check(32'(rx_pll_ref_lock), 32'h0, "pll clr");
      chk_xo(1'b0, 1'b0, "xo clr");
      $display("test soft reset done");

      // Unmapped index reads zero and leaves mapped state alone
      wr_reg(5'h05, 32'h0000_FFFF);
      rd_reg(5'h05, rd);
      check(rd, 32'h0000_0000, "unmapped");
      rd_reg(`PMX_IDX_SPECIAL, rd);
      check(rd, 32'h0000_8000, "special kept");
      $display("test unmapped done");
      stop_test();
   end
endmodule // testbench
`default_nettype wire
